// ===== verilog/acw_cell_fmt.sv
`timescale 1ns/1ps
`include "acw_consts.svh"

module acw_cell_fmt
   import acw_pkg::*;
#(
   parameter int FIFO_DEPTH = `ACW_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic rx_bad_header_pass_enable,
   input wire logic tx_hec_insert_enable,
   input wire logic rx_line_valid,
   output logic rx_line_ready,
   input wire acw_word_t rx_line_word,
   input wire logic rx_line_hdr_bad,
   output logic rx_cell_valid,
   input wire logic rx_cell_ready,
   output logic rx_cell_start_marker,
   output logic [7:0] rx_cell_data,
   input wire logic tx_cell_valid,
   output logic tx_cell_ready,
   input wire logic tx_cell_start_marker,
   input wire logic [7:0] tx_cell_data,
   output logic tx_line_valid,
   input wire logic tx_line_ready,
   output acw_word_t tx_line_word
);

   // ==========================================================
   // Parameter check
   initial begin
      if (FIFO_DEPTH < 2) begin
         $error("acw_cell_fmt: FIFO_DEPTH must be at least 2");
      end
   end

   // ==========================================================
   // Helpers
   // One CRC step per octet, bit 7 taken first as on the line
   function automatic logic [7:0] acw_crc8(input logic [7:0] crc,
                                            input logic [7:0] octet);
      logic [7:0] c;
      c = crc;
      for (int i = 7; i >= 0; i--) begin
         if (c[7] ^ octet[i]) begin
            c = {c[6:0], 1'b0} ^ `ACW_HEC_POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      return c;
   endfunction

   function automatic logic [`ACW_CNT_W-1:0] acw_next_cnt(
      input logic [`ACW_CNT_W-1:0] cnt);
      acw_next_cnt = (cnt == `ACW_LAST_CNT) ? '0 : cnt + 1'b1;
   endfunction

   // ==========================================================
   // Control pin synchronisers
   // Straps may change at any time; a change lands on a cell
   // boundary only by chance, so set them while idle.
   logic [1:0] pin_meta_q;
   logic [1:0] pin_sync_q;
   logic pass_bad;
   logic hec_insert;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_q <= 2'h0;
         pin_sync_q <= 2'h0;
      end else begin
         pin_meta_q <= {tx_hec_insert_enable, rx_bad_header_pass_enable};
         pin_sync_q <= pin_meta_q;
      end
   end

   assign pass_bad = pin_sync_q[0];
   assign hec_insert = pin_sync_q[1];

   // ==========================================================
   // Receive: cell delineation and header screening
   acw_rx_state_t rx_state_q;
   logic [`ACW_CNT_W-1:0] rx_cnt_q;
   logic rx_take;
   logic rx_keep_new;
   logic rx_fifo_wr;
   logic rx_fifo_ready;
   logic rx_discard;
   acw_word_t rx_fifo_in;
   acw_word_t rx_fifo_out;

   // Uncorrectable header dropped unless pass enabled
   assign rx_keep_new = !rx_line_hdr_bad || pass_bad;
   assign rx_discard = (rx_state_q == ACW_RX_DROP) ||
                       ((rx_state_q == ACW_RX_HUNT) &&
                        !(rx_line_word.start && rx_keep_new));
   assign rx_line_ready = rx_fifo_ready || rx_discard;
   assign rx_take = rx_line_valid && rx_line_ready;
   assign rx_fifo_wr = rx_take && !rx_discard;

   // Marker rebuilt from position, status bit never stored
   assign rx_fifo_in.start = (rx_state_q == ACW_RX_HUNT);
   assign rx_fifo_in.data = rx_line_word.data;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_state_q <= ACW_RX_HUNT;
         rx_cnt_q <= '0;
      end else if (rx_take) begin
         case (rx_state_q)
            ACW_RX_HUNT: begin
               if (rx_line_word.start) begin
                  rx_cnt_q <= acw_next_cnt(rx_cnt_q);
                  rx_state_q <= rx_keep_new ? ACW_RX_PASS : ACW_RX_DROP;
               end
            end
            ACW_RX_PASS, ACW_RX_DROP: begin
               rx_cnt_q <= acw_next_cnt(rx_cnt_q);
               if (rx_cnt_q == `ACW_LAST_CNT) begin
                  rx_state_q <= ACW_RX_HUNT;
               end
            end
            default: begin
               rx_state_q <= ACW_RX_HUNT;
               rx_cnt_q <= '0;
            end
         endcase
      end
   end

   // ==========================================================
   // Receive buffer toward the cell layer
   // Back-pressure from the cell side stalls the line side
   // through rx_line_ready once the buffer fills.
   acw_fifo #(
      .WIDTH($bits(acw_word_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_rx_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(rx_fifo_wr),
      .in_ready(rx_fifo_ready),
      .in_data(rx_fifo_in),
      .out_valid(rx_cell_valid),
      .out_ready(rx_cell_ready),
      .out_data(rx_fifo_out)
   );

   assign rx_cell_start_marker = rx_fifo_out.start;
   assign rx_cell_data = rx_fifo_out.data;

   // ==========================================================
   // Transmit: header check octet and output stage
   logic tx_busy_q;
   logic [`ACW_CNT_W-1:0] tx_cnt_q;
   logic [7:0] tx_crc_q;
   logic tx_out_valid_q;
   acw_word_t tx_out_q;
   logic tx_take;
   logic tx_load;
   logic tx_first;

   assign tx_cell_ready = !tx_out_valid_q || tx_line_ready;
   assign tx_take = tx_cell_valid && tx_cell_ready;
   // Words before a marker have no cell to belong to
   assign tx_first = !tx_busy_q && tx_cell_start_marker;
   assign tx_load = tx_take && (tx_busy_q || tx_cell_start_marker);
   assign tx_line_valid = tx_out_valid_q;
   assign tx_line_word = tx_out_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_busy_q <= 1'b0;
         tx_cnt_q <= '0;
      end else if (tx_load) begin
         tx_cnt_q <= acw_next_cnt(tx_cnt_q);
         tx_busy_q <= (tx_cnt_q != `ACW_LAST_CNT);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_crc_q <= `ACW_HEC_INIT;
      end else if (tx_load && tx_cnt_q <= `ACW_HDR_LAST_CNT) begin
         tx_crc_q <= acw_crc8(tx_first ? `ACW_HEC_INIT : tx_crc_q,
                              tx_cell_data);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_out_valid_q <= 1'b0;
         tx_out_q <= '0;
      end else if (tx_load) begin
         tx_out_valid_q <= 1'b1;
         tx_out_q.start <= tx_first;
         if (tx_cnt_q == `ACW_HEC_CNT && hec_insert) begin
            tx_out_q.data <= tx_crc_q ^ `ACW_HEC_COSET;
         end else begin
            tx_out_q.data <= tx_cell_data;
         end
      end else if (tx_line_ready) begin
         tx_out_valid_q <= 1'b0;
      end
   end

   // ==========================================================
   // Checks
   logic [`ACW_CNT_W-1:0] rx_out_cnt_q;
   logic [`ACW_CNT_W-1:0] tx_out_cnt_q;
   logic [7:0] tx_chk_crc_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_out_cnt_q <= '0;
         tx_out_cnt_q <= '0;
      end else begin
         if (rx_cell_valid && rx_cell_ready) begin
            rx_out_cnt_q <= acw_next_cnt(rx_out_cnt_q);
         end
         if (tx_line_valid && tx_line_ready) begin
            tx_out_cnt_q <= acw_next_cnt(tx_out_cnt_q);
         end
      end
   end

   // CRC rebuilt from the words as they leave, so word 5 is judged on the output side
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_chk_crc_q <= `ACW_HEC_INIT;
      end else if (tx_line_valid && tx_line_ready && tx_out_cnt_q <= `ACW_HDR_LAST_CNT) begin
         tx_chk_crc_q <= acw_crc8((tx_out_cnt_q == '0) ? `ACW_HEC_INIT : tx_chk_crc_q,
                                  tx_line_word.data);
      end
   end

   sequence s_rx_bad_start;
      rx_take && rx_state_q == ACW_RX_HUNT && rx_line_word.start &&
      rx_line_hdr_bad && !pass_bad;
   endsequence

   sequence s_rx_bad_pass;
      rx_take && rx_state_q == ACW_RX_HUNT && rx_line_word.start &&
      rx_line_hdr_bad && pass_bad;
   endsequence

   sequence s_tx_open;
      tx_load && tx_first;
   endsequence

   chk_rx_marker_pos: assert property (@(posedge clk) disable iff (!rst_n)
      rx_cell_valid |-> rx_cell_start_marker == (rx_out_cnt_q == '0))
      else $error("receive marker not on word 1");

   chk_rx_drop_bad: assert property (@(posedge clk) disable iff (!rst_n)
      s_rx_bad_start |-> !rx_fifo_wr ##1 (!rx_fifo_wr || rx_fifo_in.start) [*8])
      else $error("bad-header cell was forwarded");

   chk_rx_pass_bad: assert property (@(posedge clk) disable iff (!rst_n)
      s_rx_bad_pass |-> rx_fifo_wr && rx_fifo_in.start)
      else $error("bad-header cell not forwarded with pass enabled");

   chk_rx_cell_end: assert property (@(posedge clk) disable iff (!rst_n)
      rx_take && rx_state_q != ACW_RX_HUNT && rx_cnt_q == `ACW_LAST_CNT
      |=> rx_state_q == ACW_RX_HUNT && rx_cnt_q == '0)
      else $error("receive cell not closed after 53 words");

   chk_rx_stall: assert property (@(posedge clk) disable iff (!rst_n)
      rx_state_q == ACW_RX_PASS && !rx_fifo_ready |-> !rx_line_ready ##1 $stable(rx_cnt_q))
      else $error("line accepted while buffer full");

   chk_tx_marker_pos: assert property (@(posedge clk) disable iff (!rst_n)
      tx_line_valid |-> tx_line_word.start == (tx_out_cnt_q == '0))
      else $error("transmit marker not on word 1");

   chk_tx_hec_word: assert property (@(posedge clk) disable iff (!rst_n)
      tx_load && tx_cnt_q == `ACW_HEC_CNT && !hec_insert
      |=> tx_line_valid && tx_line_word.data == $past(tx_cell_data))
      else $error("supplied word 5 altered while insertion off");

   chk_tx_hold: assert property (@(posedge clk) disable iff (!rst_n)
      tx_line_valid && !tx_line_ready |=> tx_line_valid && $stable(tx_line_word))
      else $error("transmit word dropped under back-pressure");

   chk_tx_idle_drop: assert property (@(posedge clk) disable iff (!rst_n)
      tx_take && !tx_busy_q && !tx_cell_start_marker |=> !tx_busy_q)
      else $error("cell opened without a start marker");

   chk_tx_open_word: assert property (@(posedge clk) disable iff (!rst_n)
      s_tx_open |=> tx_line_valid && tx_line_word.start &&
      tx_line_word.data == $past(tx_cell_data))
      else $error("first transmit word not marked or altered");

   chk_tx_cell_len: assert property (@(posedge clk) disable iff (!rst_n)
      tx_load && tx_cnt_q == `ACW_LAST_CNT |=> !tx_busy_q && tx_cnt_q == '0)
      else $error("transmit cell not closed after 53 words");

   chk_tx_hec_calc: assert property (@(posedge clk) disable iff (!rst_n)
      tx_line_valid && tx_out_cnt_q == `ACW_HEC_CNT && hec_insert
      |-> tx_line_word.data == (tx_chk_crc_q ^ `ACW_HEC_COSET))
      else $error("computed header check octet is wrong");

endmodule

// ===== verilog/acw_consts.svh
`ifndef ACW_CONSTS_SVH
`define ACW_CONSTS_SVH

// ==========================================================
// Cell structure
`define ACW_WORD_BITS 8
`define ACW_CNT_W 6
`define ACW_LAST_CNT 6'h34
`define ACW_HDR_LAST_CNT 6'h03
`define ACW_HEC_CNT 6'h04

// ==========================================================
// Header check octet
`define ACW_HEC_POLY 8'h07
`define ACW_HEC_COSET 8'h55
`define ACW_HEC_INIT 8'h00

// ==========================================================
// Buffering
`define ACW_FIFO_DEPTH 32

`endif

// ===== verilog/acw_pkg.sv
package acw_pkg;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic start;
      logic [7:0] data;
   } acw_word_t;

   // ==========================================================
   // States
   typedef enum logic [1:0] {
      ACW_RX_HUNT,
      ACW_RX_PASS,
      ACW_RX_DROP
   } acw_rx_state_t;

endpackage

// ===== verilog/acw_fifo.sv
`timescale 1ns/1ps

module acw_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   // ==========================================================
   // Parameter check
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
         $error("acw_fifo: DEPTH must be a power of two >= 2");
      end
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [AW:0] count_q;
   logic out_valid_q;
   logic [WIDTH-1:0] out_data_q;
   logic push;
   logic pop;

   // ==========================================================
   // Handshake
   // Read data always come from the output register, so the
   // memory holds DEPTH words and the register one more.
   assign in_ready = (count_q != (AW+1)'(DEPTH));
   assign push = in_valid && in_ready;
   assign pop = (count_q != '0) && (!out_valid_q || out_ready);
   assign out_valid = out_valid_q;
   assign out_data = out_data_q;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         if (push && !pop) begin
            count_q <= count_q + 1'b1;
         end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_valid_q <= 1'b0;
         out_data_q <= '0;
      end else if (pop) begin
         out_valid_q <= 1'b1;
         out_data_q <= mem_q[rd_ptr_q];
      end else if (out_ready) begin
         out_valid_q <= 1'b0;
      end
   end

   chk_fifo_full_block: assert property (@(posedge clk) disable iff (!rst_n)
      (count_q == (AW+1)'(DEPTH)) && !pop |=> count_q == (AW+1)'(DEPTH))
      else $error("fifo count moved while full without a pop");
endmodule

// ===== testbench/acw_atm_layer.sv
`timescale 1ns/1ps

// ==========================================================
// Cell layer partner: drains receive cells, sources transmit cells
module acw_atm_layer
   import acw_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic stall,
   input wire logic rx_cell_valid,
   output logic rx_cell_ready,
   input wire logic rx_cell_start_marker,
   input wire logic [7:0] rx_cell_data,
   output logic tx_cell_valid,
   input wire logic tx_cell_ready,
   output logic tx_cell_start_marker,
   output logic [7:0] tx_cell_data
);
   acw_word_t rx_q[$];

   initial begin
      tx_cell_valid = 1'b0;
      tx_cell_start_marker = 1'b0;
      tx_cell_data = 8'h00;
   end

   // Stall is how the bench fills the receive buffer
   assign rx_cell_ready = !stall;

   always @(posedge clk) begin
      if (rst_n && rx_cell_valid && rx_cell_ready) begin
         rx_q.push_back({rx_cell_start_marker, rx_cell_data});
      end
   end

   // Each word held until taken; released data is inverted so a stale byte never passes
   task automatic send_cell(input logic [7:0] base);
      for (int i = 0; i < 53; i++) begin
         tx_cell_valid <= 1'b1;
         tx_cell_start_marker <= (i == 0);
         tx_cell_data <= base + 8'(i);
         do @(posedge clk); while (!tx_cell_ready);
      end
      tx_cell_valid <= 1'b0;
      tx_cell_start_marker <= 1'b0;
      tx_cell_data <= ~tx_cell_data;
      @(posedge clk);
   endtask
endmodule

// ===== testbench/acw_cell_word_format_tb_top.sv
`timescale 1ns/1ps

// ==========================================================
// Testbench top
module atm_cell_word_format_tb_top
   import acw_pkg::*;
;
   typedef struct packed {
      logic pass;
      logic bad;
      logic ins;
      logic fwd;
   } acw_row_t;

   acw_row_t rows[4] = '{'{1'b0, 1'b0, 1'b1, 1'b1}, '{1'b0, 1'b1, 1'b0, 1'b0},
                         '{1'b1, 1'b1, 1'b1, 1'b1}, '{1'b1, 1'b0, 1'b0, 1'b1}};
   logic clk, rst_n, pass_en, ins_en, stall;
   logic rx_line_valid, rx_line_ready, rx_line_hdr_bad;
   logic rx_cell_valid, rx_cell_ready, rx_cell_start_marker;
   logic tx_cell_valid, tx_cell_ready, tx_cell_start_marker;
   logic tx_line_valid, tx_line_ready;
   logic [7:0] rx_cell_data;
   logic [7:0] tx_cell_data;
   logic [7:0] base;
   acw_word_t rx_line_word;
   acw_word_t tx_line_word;
   acw_word_t tx_q[$];
   int err_count;
   int total_checks;
   int refused;

   acw_cell_fmt #(.FIFO_DEPTH(32)) dut (.clk(clk), .rst_n(rst_n),
      .rx_bad_header_pass_enable(pass_en), .tx_hec_insert_enable(ins_en),
      .rx_line_valid(rx_line_valid), .rx_line_ready(rx_line_ready),
      .rx_line_word(rx_line_word), .rx_line_hdr_bad(rx_line_hdr_bad),
      .rx_cell_valid(rx_cell_valid), .rx_cell_ready(rx_cell_ready),
      .rx_cell_start_marker(rx_cell_start_marker), .rx_cell_data(rx_cell_data),
      .tx_cell_valid(tx_cell_valid), .tx_cell_ready(tx_cell_ready),
      .tx_cell_start_marker(tx_cell_start_marker), .tx_cell_data(tx_cell_data),
      .tx_line_valid(tx_line_valid), .tx_line_ready(tx_line_ready),
      .tx_line_word(tx_line_word));

   acw_atm_layer p (.clk(clk), .rst_n(rst_n), .stall(stall),
      .rx_cell_valid(rx_cell_valid), .rx_cell_ready(rx_cell_ready),
      .rx_cell_start_marker(rx_cell_start_marker), .rx_cell_data(rx_cell_data),
      .tx_cell_valid(tx_cell_valid), .tx_cell_ready(tx_cell_ready),
      .tx_cell_start_marker(tx_cell_start_marker), .tx_cell_data(tx_cell_data));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk) begin
      if (rst_n && tx_line_valid && tx_line_ready) begin
         tx_q.push_back(tx_line_word);
      end
      if (rx_line_valid && !rx_line_ready) begin
         refused++;
      end
   end

   // ==========================================================
   // Helpers
   function automatic logic [7:0] hec(input logic [7:0] b);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 4; i++) begin
         c = c ^ (b + 8'(i));
         for (int k = 0; k < 8; k++) begin
            c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
         end
      end
      return c ^ 8'h55;
   endfunction

   task automatic chk_word(input acw_word_t got, input acw_word_t exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: word %h, want %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: flag %b, want %b", $time, got, exp);
      end
   endtask

   task automatic chk_count(input int got, input int exp);
      total_checks++;
      if (got != exp) begin
         err_count++;
         $display("unexpected at %0t: count %0d, want %0d", $time, got, exp);
      end
   endtask

   task automatic chk_cell(input acw_word_t q[$], input logic [7:0] b, input logic [7:0] w5);
      chk_count(q.size(), 53);
      for (int i = 0; i < q.size() && i < 53; i++) begin
         chk_word(q[i], {(i == 0), (i == 4) ? w5 : b + 8'(i)});
      end
   endtask

   // Held until taken; one idle edge after release avoids double drive
   task automatic send_rx(input logic [7:0] b, input logic bad, input int n, input logic st);
      for (int i = 0; i < n; i++) begin
         rx_line_valid <= 1'b1;
         rx_line_word <= {st && (i == 0), b + 8'(i)};
         rx_line_hdr_bad <= bad;
         do @(posedge clk); while (!rx_line_ready);
      end
      rx_line_valid <= 1'b0;
      rx_line_word <= ~rx_line_word;
      @(posedge clk);
   endtask

   task automatic wait_q(input int rn, input int tn);
      for (int i = 0; i < 400; i++) begin
         if (p.rx_q.size() >= rn && tx_q.size() >= tn) break;
         @(posedge clk);
      end
      repeat (5) @(posedge clk);
   endtask

   task automatic end_of_test();
      $display("checks %0d, errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ==========================================================
   // Sequence
   initial begin
      rst_n = 1'b0;
      pass_en = 1'b0;
      ins_en = 1'b0;
      stall = 1'b0;
      rx_line_valid = 1'b0;
      rx_line_word = '0;
      rx_line_hdr_bad = 1'b0;
      tx_line_ready = 1'b1;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      foreach (rows[k]) begin
         base = 8'(k * 64 + 17);
         pass_en <= rows[k].pass;
         ins_en <= rows[k].ins;
         repeat (3) @(posedge clk);
         fork
            begin
               send_rx(8'hE0, 1'b0, 3, 1'b0);
               send_rx(base, rows[k].bad, 53, 1'b1);
            end
            p.send_cell(base);
         join
         wait_q(rows[k].fwd ? 53 : 0, 53);
         if (rows[k].fwd) chk_cell(p.rx_q, base, base + 8'h04);
         else chk_count(p.rx_q.size(), 0);
         chk_cell(tx_q, base, rows[k].ins ? hec(base) : base + 8'h04);
         p.rx_q.delete();
         tx_q.delete();
      end
      // Both sides stalled: buffer refuses, then two cells drain intact
      pass_en <= 1'b0;
      ins_en <= 1'b1;
      stall <= 1'b1;
      tx_line_ready <= 1'b0;
      refused = 0;
      fork
         begin
            send_rx(8'h21, 1'b0, 53, 1'b1);
            send_rx(8'h62, 1'b0, 53, 1'b1);
         end
         p.send_cell(8'h33);
         begin
            repeat (120) @(posedge clk);
            stall <= 1'b0;
            tx_line_ready <= 1'b1;
         end
      join
      wait_q(106, 53);
      chk_bit(refused > 0, 1'b1);
      chk_cell(p.rx_q[0:52], 8'h21, 8'h25);
      chk_cell(p.rx_q[53:105], 8'h62, 8'h66);
      chk_cell(tx_q, 8'h33, hec(8'h33));
      // Reset in mid-cell on both sides; the cut transmit cell must not resume
      tx_line_ready <= 1'b0;
      fork
         p.send_cell(8'h70);
         begin
            send_rx(8'h44, 1'b0, 20, 1'b1);
            rst_n <= 1'b0;
            @(posedge clk);
            #1;
            chk_bit(rx_cell_valid, 1'b0);
            chk_bit(tx_line_valid, 1'b0);
            chk_bit(rx_line_ready, 1'b1);
            repeat (3) @(posedge clk);
            rst_n <= 1'b1;
            tx_line_ready <= 1'b1;
            p.rx_q.delete();
            tx_q.delete();
         end
      join
      repeat (3) @(posedge clk);
      send_rx(8'h55, 1'b0, 53, 1'b1);
      wait_q(53, 0);
      chk_cell(p.rx_q, 8'h55, 8'h59);
      chk_count(tx_q.size(), 0);
      end_of_test();
   end

   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      end_of_test();
   end
endmodule
